// File: design/smd_regs.sv
/*
  shadow image, volatile register map, margin checker and diagnostic forwarding of the sensor.
  assumes a decoded programming command port, a request/acknowledge port to the non-volatile array,
  and pulse markers from the output encoders for period, frame and serial message starts.
*/
// Notes on behaviour
// - error bits latched same cycle, forwarded later
// - pulse-width output updates at next period
// - frame output updates at next frame
// - serial message updates only at message build
// - analog error response applied immediately
// - diagnostic bits clear when condition gone
// - every error shown one full period/frame
// - power-up copies non-volatile words to shadow
// - shadow replaced by direct write or reprogram
// - shadow sits at offset plus 0x40
// - unused shadow bits absent, read zero
// - shadow holds data bits, no check bits
// - unlock needed before memory reads
// - analog mode needs access code first
// - wafer and die fields readable without unlock
// - no reply to nonexistent register reads
// - shadow uses same transaction format
// - repeat bit tests only addressed word
// - pointer captures latest highest failing word
// - custom start lets host set pointer
// - custom select picks start word
// - run bit starts, self-clears, clear aborts
// - progress code and fail side reported
// - masked error flags stay deasserted
// - port force tristates output, keeps link
`timescale 1ns/1ps
`include "smd_defines.svh"

module smd_regs #(
  parameter int DEPTH = 64,
  parameter int DW = 26,
  parameter int NVM_W = 32,
  parameter logic [25:0] USED_BITS = 26'h3ff_ffff
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // programming command port
  input wire logic cmdValid,
  input wire logic cmdWrite,
  input wire logic [7:0] cmdAddr,
  input wire logic [31:0] cmdWdata,
  output logic cmdReady,
  output logic rspValid,
  output logic [31:0] rspData,
  // unlock events
  input wire logic customerUnlock,
  input wire logic accessCodeOk,
  // non-volatile array port
  output logic nvmReq,
  output logic nvmWe,
  output logic [$clog2(DEPTH)-1:0] nvmAddr,
  output logic [NVM_W-1:0] nvmWdata,
  output logic [1:0] nvmMargin,
  input wire logic nvmAck,
  input wire logic [NVM_W-1:0] nvmRdata,
  input wire logic nvmMarginFail,
  // output encoder
  input wire logic [1:0] outMode,
  input wire logic pwmPeriodStart,
  input wire logic sentFrameStart,
  input wire logic serialMsgStart,
  output logic [`SMD_NUM_ERR-1:0] diagPwm,
  output logic [`SMD_NUM_ERR-1:0] diagSent,
  output logic [`SMD_NUM_ERR-1:0] diagSerial,
  output logic [`SMD_NUM_ERR-1:0] diagAnalog,
  output logic portForce,
  // error conditions and self test
  input wire logic [`SMD_NUM_ERR-1:0] errCond,
  output logic lbistStart,
  input wire logic lbistDone,
  input wire logic lbistPass,
  input wire logic [31:0] lbistSig,
  // measurement readouts
  input wire logic [15:0] tempVal,
  input wire logic [15:0] angleVal,
  input wire logic [15:0] chanA,
  input wire logic [15:0] chanB,
  input wire logic [15:0] chanAPre,
  input wire logic [15:0] chanBPre,
  input wire logic [`SMD_RADIUS_W-1:0] radiusSq,
  // configuration image
  output logic [DEPTH-1:0][DW-1:0] shadowImage
);
  localparam int AW = $clog2(DEPTH);
  localparam int NE = `SMD_NUM_ERR;
  localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

  typedef struct packed {
    smd_pkg::smd_state_e state;
    logic [AW-1:0] ptr;
    logic waitAck;
    logic [DEPTH-1:0][DW-1:0] shadow;
    logic cmdReady;
    logic rspValid;
    logic [31:0] rspData;
    logic nvmReq;
    logic nvmWe;
    logic [AW-1:0] nvmAddr;
    logic [NVM_W-1:0] nvmWdata;
    logic [1:0] nvmMargin;
    logic mRun;
    logic mMaxDis;
    logic mMinDis;
    logic [1:0] mProg;
    logic mSide;
    logic mCsel;
    logic [5:0] mPtr;
    logic mRepeat;
    logic mFail;
    logic mUpper;
    logic unlocked;
    logic accessOk;
    logic portForce;
    logic lbistStart;
    logic [NE-1:0] errLat;
    logic [2:0][NE-1:0] pend;
    logic [2:0][NE-1:0] diag;
    logic [NE-1:0] diagAnalog;
  } smd_state_s;

  localparam smd_state_s RST_ST = '{state: smd_pkg::ST_LOAD, rspData: `SMD_RSP_RESET, default: '0};

  smd_state_s st_r;
  smd_state_s st_nxt;

  always_comb begin
    logic [NE-1:0] newLat;
    logic [2:0] boundary;
    logic accept;
    logic isShadow;
    logic isNvm;
    logic idRead;
    logic [AW-1:0] idx;
    logic [DW-1:0] ackData;
    newLat = '0;
    boundary = '0;
    accept = 1'b0;
    isShadow = 1'b0;
    isNvm = 1'b0;
    idRead = 1'b0;
    idx = '0;
    ackData = '0;
    st_nxt = st_r;
    st_nxt.rspValid = 1'b0;
    st_nxt.nvmReq = 1'b0;
    st_nxt.lbistStart = 1'b0;

    // diagnostic capture and forwarding
    newLat = errCond & ~st_r.shadow[`SMD_MASK_IDX][NE-1:0];
    st_nxt.errLat = newLat;
    st_nxt.diagAnalog = newLat;
    boundary = {serialMsgStart, sentFrameStart, pwmPeriodStart};
    for (int c = 0; c < 3; c++) begin
      if (boundary[c]) begin
        st_nxt.diag[c] = st_r.pend[c] | newLat;
        st_nxt.pend[c] = newLat;
      end else begin
        st_nxt.pend[c] = st_r.pend[c] | newLat;
      end
    end

    ackData = nvmRdata[DW-1:0] & USED_BITS;

    case (st_r.state)
      smd_pkg::ST_LOAD: begin
        if (!st_r.waitAck) begin
          st_nxt.nvmReq = 1'b1;
          st_nxt.nvmWe = 1'b0;
          st_nxt.nvmAddr = st_r.ptr;
          st_nxt.nvmMargin = smd_pkg::MRG_NORMAL;
          st_nxt.waitAck = 1'b1;
        end else if (nvmAck) begin
          st_nxt.waitAck = 1'b0;
          st_nxt.shadow[st_r.ptr] = ackData;
          if (st_r.ptr == LAST) begin
            st_nxt.ptr = '0;
            st_nxt.state = smd_pkg::ST_IDLE;
          end else begin
            st_nxt.ptr = st_r.ptr + AW'(1);
          end
        end
      end
      smd_pkg::ST_NVMRD: begin
        if (!st_r.waitAck) begin
          st_nxt.nvmReq = 1'b1;
          st_nxt.nvmWe = 1'b0;
          st_nxt.nvmAddr = st_r.ptr;
          st_nxt.nvmMargin = smd_pkg::MRG_NORMAL;
          st_nxt.waitAck = 1'b1;
        end else if (nvmAck) begin
          st_nxt.waitAck = 1'b0;
          st_nxt.rspValid = 1'b1;
          st_nxt.rspData = 32'(ackData);
          st_nxt.state = smd_pkg::ST_IDLE;
        end
      end
      smd_pkg::ST_NVMWR: begin
        if (!st_r.waitAck) begin
          st_nxt.nvmReq = 1'b1;
          st_nxt.nvmWe = 1'b1;
          st_nxt.nvmAddr = st_r.ptr;
          st_nxt.nvmMargin = smd_pkg::MRG_NORMAL;
          st_nxt.waitAck = 1'b1;
        end else if (nvmAck) begin
          st_nxt.waitAck = 1'b0;
          st_nxt.shadow[st_r.ptr] = st_r.nvmWdata[DW-1:0] & USED_BITS;
          st_nxt.state = smd_pkg::ST_IDLE;
        end
      end
      smd_pkg::ST_MARGIN: begin
        if (!st_r.waitAck) begin
          if (!st_r.mRun) begin
            st_nxt.mProg = smd_pkg::PROG_NOTRUN;
            st_nxt.state = smd_pkg::ST_IDLE;
          end else begin
            st_nxt.nvmReq = 1'b1;
            st_nxt.nvmWe = 1'b0;
            st_nxt.nvmAddr = st_r.ptr;
            st_nxt.nvmMargin = st_r.mUpper ? smd_pkg::MRG_UPPER : smd_pkg::MRG_LOWER;
            st_nxt.waitAck = 1'b1;
          end
        end else if (nvmAck) begin
          st_nxt.waitAck = 1'b0;
          if (nvmMarginFail) begin
            st_nxt.mFail = 1'b1;
            st_nxt.mPtr = 6'(st_r.ptr);
            st_nxt.mSide = st_r.mUpper;
          end
          if (!st_r.mUpper && !st_r.mMaxDis) begin
            st_nxt.mUpper = 1'b1;
          end else begin
            st_nxt.mUpper = st_r.mMinDis;
            if (st_r.mRepeat) begin
              st_nxt.ptr = st_r.ptr;
            end else if (st_r.ptr == LAST) begin
              st_nxt.mRun = 1'b0;
              st_nxt.mProg = (st_r.mFail || nvmMarginFail) ? smd_pkg::PROG_FAIL : smd_pkg::PROG_PASS;
              st_nxt.state = smd_pkg::ST_IDLE;
            end else begin
              st_nxt.ptr = st_r.ptr + AW'(1);
            end
          end
        end
      end
      default: begin
        st_nxt.state = smd_pkg::ST_IDLE;
      end
    endcase

    // command decode
    accept = cmdValid && st_r.cmdReady && (outMode != smd_pkg::MODE_ANALOG || st_r.accessOk);
    isNvm = cmdAddr < `SMD_SHADOW_OFS;
    isShadow = cmdAddr >= `SMD_SHADOW_OFS && cmdAddr <= `SMD_SHADOW_TOP;
    idRead = cmdAddr == `SMD_WAFER_ID_LO || cmdAddr == `SMD_WAFER_ID_HI;
    idx = cmdAddr[AW-1:0];
    if (accept && (isNvm || isShadow) && st_r.state == smd_pkg::ST_MARGIN) begin
      accept = 1'b0;
    end
    if (accept && cmdWrite) begin
      if (isNvm) begin
        if (st_r.unlocked) begin
          st_nxt.ptr = idx;
          st_nxt.nvmWdata = cmdWdata[NVM_W-1:0];
          st_nxt.state = smd_pkg::ST_NVMWR;
        end
      end else if (isShadow) begin
        if (st_r.unlocked) begin
          st_nxt.shadow[idx] = cmdWdata[DW-1:0] & USED_BITS;
        end
      end else if (cmdAddr == `SMD_ADDR_MARGIN) begin
        if (st_r.mRun) begin
          st_nxt.mRun = st_nxt.mRun && cmdWdata[`SMD_MRG_RUN];
        end else begin
          st_nxt.mMaxDis = cmdWdata[`SMD_MRG_MAXDIS];
          st_nxt.mMinDis = cmdWdata[`SMD_MRG_MINDIS];
          st_nxt.mCsel = cmdWdata[`SMD_MRG_CSEL];
          st_nxt.mRepeat = cmdWdata[`SMD_MRG_REPEAT];
          if (cmdWdata[`SMD_MRG_CSEL]) begin
            st_nxt.mPtr = cmdWdata[`SMD_MRG_PTR_LSB +: 6];
          end
          if (cmdWdata[`SMD_MRG_RUN]) begin
            st_nxt.mRun = 1'b1;
            st_nxt.mProg = smd_pkg::PROG_RUN;
            st_nxt.mFail = 1'b0;
            st_nxt.mUpper = cmdWdata[`SMD_MRG_MINDIS];
            st_nxt.ptr = cmdWdata[`SMD_MRG_CSEL] ? AW'(cmdWdata[`SMD_MRG_PTR_LSB +: 6]) : '0;
            st_nxt.state = smd_pkg::ST_MARGIN;
            if (cmdWdata[`SMD_MRG_MINDIS] && cmdWdata[`SMD_MRG_MAXDIS]) begin
              st_nxt.mRun = 1'b0;
              st_nxt.mProg = smd_pkg::PROG_PASS;
              st_nxt.state = smd_pkg::ST_IDLE;
            end
          end
        end
      end else if (cmdAddr == `SMD_ADDR_FORCE) begin
        st_nxt.portForce = cmdWdata[`SMD_FORCE_PORT];
        st_nxt.lbistStart = cmdWdata[`SMD_FORCE_BIST];
      end else if (cmdAddr == `SMD_ADDR_SWRST) begin
        if (cmdWdata[`SMD_SWRST_BIT]) begin
          st_nxt = RST_ST;
        end
      end
    end else if (accept) begin
      st_nxt.rspValid = 1'b1;
      st_nxt.rspData = '0;
      if (isNvm) begin
        st_nxt.rspValid = 1'b0;
        if (st_r.unlocked || idRead) begin
          st_nxt.ptr = idx;
          st_nxt.state = smd_pkg::ST_NVMRD;
        end
      end else if (isShadow) begin
        if (st_r.unlocked || (idRead | (cmdAddr == (`SMD_WAFER_ID_LO | `SMD_SHADOW_OFS)) |
            (cmdAddr == (`SMD_WAFER_ID_HI | `SMD_SHADOW_OFS)))) begin
          st_nxt.rspData = 32'(st_r.shadow[idx]);
        end else begin
          st_nxt.rspValid = 1'b0;
        end
      end else if (cmdAddr == `SMD_ADDR_MARGIN) begin
        st_nxt.rspData[`SMD_MRG_RUN] = st_r.mRun;
        st_nxt.rspData[`SMD_MRG_MAXDIS] = st_r.mMaxDis;
        st_nxt.rspData[`SMD_MRG_MINDIS] = st_r.mMinDis;
        st_nxt.rspData[`SMD_MRG_PROG_LSB +: 2] = st_r.mProg;
        st_nxt.rspData[`SMD_MRG_SIDE] = st_r.mSide;
        st_nxt.rspData[`SMD_MRG_CSEL] = st_r.mCsel;
        st_nxt.rspData[`SMD_MRG_PTR_LSB +: 6] = st_r.mPtr;
        st_nxt.rspData[`SMD_MRG_REPEAT] = st_r.mRepeat;
      end else if (cmdAddr == `SMD_ADDR_LBIST) begin
        st_nxt.rspData[`SMD_LBIST_DONE] = lbistDone;
        st_nxt.rspData[`SMD_LBIST_PASS] = lbistPass;
      end else if (cmdAddr == `SMD_ADDR_UNLOCK) begin
        st_nxt.rspData[`SMD_UNLOCK_MEMACC] = st_r.accessOk;
      end else if (cmdAddr == `SMD_ADDR_FORCE) begin
        st_nxt.rspData[`SMD_FORCE_PORT] = st_r.portForce;
      end else if (cmdAddr == `SMD_ADDR_SIG) begin
        st_nxt.rspData = lbistSig;
      end else if (cmdAddr == `SMD_ADDR_ERR) begin
        st_nxt.rspData = 32'(st_r.errLat);
      end else if (cmdAddr == `SMD_ADDR_TEMPANG) begin
        st_nxt.rspData = {tempVal, angleVal};
      end else if (cmdAddr == `SMD_ADDR_CHFIN) begin
        st_nxt.rspData = {chanB, chanA};
      end else if (cmdAddr == `SMD_ADDR_CHPRE) begin
        st_nxt.rspData = {chanBPre, chanAPre};
      end else if (cmdAddr == `SMD_ADDR_RADIUS) begin
        st_nxt.rspData = 32'(radiusSq);
      end else begin
        st_nxt.rspValid = 1'b0;
        st_nxt.rspData = st_r.rspData;
      end
    end

    // unlock and access code sticky until reset; set beats soft reset
    if (customerUnlock) begin
      st_nxt.unlocked = 1'b1;
    end
    if (accessCodeOk) begin
      st_nxt.accessOk = 1'b1;
    end
    st_nxt.cmdReady = st_nxt.state == smd_pkg::ST_IDLE || st_nxt.state == smd_pkg::ST_MARGIN;
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      st_r <= RST_ST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign cmdReady = st_r.cmdReady;
  assign rspValid = st_r.rspValid;
  assign rspData = st_r.rspData;
  assign nvmReq = st_r.nvmReq;
  assign nvmWe = st_r.nvmWe;
  assign nvmAddr = st_r.nvmAddr;
  assign nvmWdata = st_r.nvmWdata;
  assign nvmMargin = st_r.nvmMargin;
  assign diagPwm = st_r.diag[0];
  assign diagSent = st_r.diag[1];
  assign diagSerial = st_r.diag[2];
  assign diagAnalog = st_r.diagAnalog;
  assign portForce = st_r.portForce;
  assign lbistStart = st_r.lbistStart;
  assign shadowImage = st_r.shadow;
endmodule : smd_regs

// File: design/smd_defines.svh
/*
  register offsets, field positions and reset values of the shadow memory and diagnostic block.
  assumes a single include per compilation unit; the guard covers repeats.
*/
`ifndef SMD_DEFINES_SVH
`define SMD_DEFINES_SVH

// address map
`define SMD_SHADOW_OFS 8'h40
`define SMD_SHADOW_TOP 8'h7f
`define SMD_ADDR_MARGIN 8'h83
`define SMD_ADDR_LBIST 8'h85
`define SMD_ADDR_UNLOCK 8'h86
`define SMD_ADDR_FORCE 8'ha0
`define SMD_ADDR_SIG 8'ha1
`define SMD_ADDR_SWRST 8'ha2
`define SMD_ADDR_ERR 8'ha3
`define SMD_ADDR_TEMPANG 8'ha7
`define SMD_ADDR_CHFIN 8'ha8
`define SMD_ADDR_CHPRE 8'ha9
`define SMD_ADDR_RADIUS 8'haa
// identity words readable without unlock
`define SMD_WAFER_ID_LO 8'h3c
`define SMD_WAFER_ID_HI 8'h3d
// shadow word holding the error mask
`define SMD_MASK_IDX 6'h20

// field positions
`define SMD_MRG_RUN 0
`define SMD_MRG_MAXDIS 1
`define SMD_MRG_MINDIS 2
`define SMD_MRG_PROG_LSB 3
`define SMD_MRG_SIDE 5
`define SMD_MRG_CSEL 6
`define SMD_MRG_PTR_LSB 7
`define SMD_MRG_REPEAT 13
`define SMD_LBIST_DONE 4
`define SMD_LBIST_PASS 5
`define SMD_UNLOCK_MEMACC 1
`define SMD_FORCE_BIST 0
`define SMD_FORCE_PORT 7
`define SMD_SWRST_BIT 0

// widths and reset values
`define SMD_NUM_ERR 13
`define SMD_RADIUS_W 17
`define SMD_RSP_RESET 32'h0000_0000

`endif

// File: design/smd_pkg.sv
/*
  types of the shadow memory and diagnostic block.
  assumes smd_defines.svh supplies the numeric constants.
*/
package smd_pkg;
  typedef enum logic [4:0] {
    ST_LOAD = 5'b00001,
    ST_IDLE = 5'b00010,
    ST_NVMRD = 5'b00100,
    ST_NVMWR = 5'b01000,
    ST_MARGIN = 5'b10000
  } smd_state_e;

  typedef enum logic [1:0] {
    PROG_NOTRUN = 2'h0,
    PROG_PASS = 2'h1,
    PROG_FAIL = 2'h2,
    PROG_RUN = 2'h3
  } smd_prog_e;

  typedef enum logic [1:0] {
    MRG_NORMAL = 2'h0,
    MRG_LOWER = 2'h1,
    MRG_UPPER = 2'h2
  } smd_margin_e;

  typedef enum logic [1:0] {
    MODE_ANALOG = 2'h0,
    MODE_PWM = 2'h1,
    MODE_SENT = 2'h2
  } smd_mode_e;
endpackage : smd_pkg

// File: sim/smd_regs_assertions.sv
/*
  port checks of the shadow memory and diagnostic block.
  assumes it is bound into smd_regs; one clock domain.
*/
`timescale 1ns/1ps
module smd_regs_assertions #(
  parameter int DEPTH = 64,
  parameter int DW = 26
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // command port
  input wire logic cmdValid,
  input wire logic cmdWrite,
  input wire logic [7:0] cmdAddr,
  input wire logic cmdReady,
  input wire logic rspValid,
  // array port
  input wire logic nvmReq,
  input wire logic [1:0] nvmMargin,
  // diagnostics
  input wire logic [1:0] outMode,
  input wire logic pwmPeriodStart,
  input wire logic sentFrameStart,
  input wire logic serialMsgStart,
  input wire logic [12:0] diagPwm,
  input wire logic [12:0] diagSent,
  input wire logic [12:0] diagSerial,
  input wire logic [12:0] diagAnalog,
  input wire logic [12:0] errCond,
  input wire logic [DEPTH-1:0][DW-1:0] shadowImage
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  AST_RSP_VOLATILE: assert property (cmdValid && cmdReady && !cmdWrite && outMode != 2'h0
    && cmdAddr == 8'ha3 |=> rspValid) else $error("no reply to error register read");
  AST_NO_RSP_WO: assert property (cmdValid && cmdReady && !cmdWrite && (cmdAddr == 8'ha2
    || cmdAddr == 8'hff) |=> !rspValid) else $error("reply to absent register");
  AST_ANALOG_NOW: assert property ($past(nrst) |->
    diagAnalog == $past(errCond & ~shadowImage[32][12:0])) else $error("analog diag wrong");
  AST_PWM_HOLD: assert property ($past(nrst) && !$past(pwmPeriodStart) |-> $stable(diagPwm))
    else $error("pwm diag changed mid period");
  AST_SENT_HOLD: assert property ($past(nrst) && !$past(sentFrameStart) |-> $stable(diagSent))
    else $error("frame diag changed mid frame");
  AST_SERIAL_HOLD: assert property ($past(nrst) && !$past(serialMsgStart) |-> $stable(diagSerial))
    else $error("serial diag changed mid message");
  AST_PWM_REPORT: assert property (pwmPeriodStart |=>
    (diagPwm & $past(diagAnalog)) == $past(diagAnalog)) else $error("latched error not reported");
  AST_NVM_PULSE: assert property (nvmReq |=> !nvmReq) else $error("array request too long");
  AST_BUSY_NVM: assert property (nvmReq && nvmMargin == 2'h0 |-> !cmdReady)
    else $error("ready during array access");

  cover property (nvmReq && nvmMargin == 2'h2);
  cover property (rspValid);
  cover property (pwmPeriodStart ##1 diagPwm != 13'h0);
endmodule : smd_regs_assertions

bind smd_regs smd_regs_assertions #(.DEPTH(DEPTH), .DW(DW)) i_chk (.ref_clk(ref_clk), .nrst(nrst),
  .cmdValid(cmdValid), .cmdWrite(cmdWrite), .cmdAddr(cmdAddr), .cmdReady(cmdReady), .rspValid(rspValid),
  .nvmReq(nvmReq), .nvmMargin(nvmMargin), .outMode(outMode), .pwmPeriodStart(pwmPeriodStart),
  .sentFrameStart(sentFrameStart), .serialMsgStart(serialMsgStart), .diagPwm(diagPwm),
  .diagSent(diagSent), .diagSerial(diagSerial), .diagAnalog(diagAnalog), .errCond(errCond),
  .shadowImage(shadowImage));

// File: sim/smd_nvm_model.sv
/*
  behavioural non-volatile array on the block's request port.
  assumes one outstanding request; slow stretches each answer.
*/
`timescale 1ns/1ps
module smd_nvm_model #(
  parameter logic [5:0] FAIL_WORD = 6'h09
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // request side
  input wire logic nvmReq,
  input wire logic nvmWe,
  input wire logic [5:0] nvmAddr,
  input wire logic [31:0] nvmWdata,
  input wire logic [1:0] nvmMargin,
  input wire logic slow,
  // answer side
  output logic nvmAck,
  output logic [31:0] nvmRdata,
  output logic nvmMarginFail
);
  logic [31:0] mem [64];
  logic [5:0] addrQ;
  logic weQ;
  logic [1:0] mrgQ;
  logic [1:0] cnt;

  initial begin
    for (int i = 0; i < 64; i++) begin
      mem[i] = {i[5:0] ^ 6'h15, 20'h5a5a5, i[5:0]};
    end
    mem[32] = 32'h0;
    nvmRdata = 32'h0;
    nvmMarginFail = 1'b0;
  end

  // answer after one or three cycles; data lines toggle when idle
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      nvmAck <= 1'b0;
      cnt <= 2'h0;
    end else begin
      nvmAck <= 1'b0;
      if (nvmReq) begin
        cnt <= slow ? 2'h3 : 2'h1;
        addrQ <= nvmAddr;
        weQ <= nvmWe;
        mrgQ <= nvmMargin;
      end else if (cnt == 2'h1) begin
        cnt <= 2'h0;
        nvmAck <= 1'b1;
        nvmRdata <= mem[addrQ];
        nvmMarginFail <= (mrgQ == 2'h2 && addrQ == FAIL_WORD);
        if (weQ) begin
          mem[addrQ] <= nvmWdata;
        end
      end else if (cnt != 2'h0) begin
        cnt <= cnt - 2'h1;
      end else begin
        nvmRdata <= ~nvmRdata;
        nvmMarginFail <= ~nvmMarginFail;
      end
    end
  end
endmodule : smd_nvm_model

// File: sim/tb_top.sv
/*
  self-checking bench of the shadow memory and diagnostic block.
  assumes smd_nvm_model as the array and the bound checker.
*/
`timescale 1ns/1ps
module tb_top;
  logic ref_clk, nrst = 1'b0, cmdValid = 1'b0, cmdWrite = 1'b0, cmdReady, rspValid, got, lbSeen = 1'b0;
  logic customerUnlock = 1'b0, accessCodeOk = 1'b0, nvmReq, nvmWe, nvmAck, nvmMarginFail, portForce;
  logic lbistStart, lbistDone = 1'b1, lbistPass = 1'b1, slow = 1'b0;
  logic [7:0] cmdAddr = 8'h00;
  logic [31:0] cmdWdata = 32'h0, rspData, nvmWdata, nvmRdata, rdat, lbistSig = 32'hcafe_f00d;
  logic [5:0] nvmAddr;
  logic [1:0] nvmMargin, outMode = 2'h1;
  logic [2:0] bnd = 3'h0;
  logic [12:0] errCond = 13'h0, diagAnalog;
  logic [12:0] diagV [3];
  logic [15:0] tempVal = 16'h1234, angleVal = 16'h5678, chanA = 16'h9abc, chanB = 16'hdef0;
  logic [15:0] chanAPre = 16'h1357, chanBPre = 16'h2468;
  logic [16:0] radiusSq = 17'h1abcd;
  logic [63:0][25:0] shadowImage;
  int error_cnt = 0, total_checks = 0;

  smd_regs i_dut (.ref_clk(ref_clk), .nrst(nrst), .cmdValid(cmdValid), .cmdWrite(cmdWrite),
    .cmdAddr(cmdAddr), .cmdWdata(cmdWdata), .cmdReady(cmdReady), .rspValid(rspValid), .rspData(rspData),
    .customerUnlock(customerUnlock), .accessCodeOk(accessCodeOk), .nvmReq(nvmReq), .nvmWe(nvmWe),
    .nvmAddr(nvmAddr), .nvmWdata(nvmWdata), .nvmMargin(nvmMargin), .nvmAck(nvmAck), .nvmRdata(nvmRdata),
    .nvmMarginFail(nvmMarginFail), .outMode(outMode), .pwmPeriodStart(bnd[0]), .sentFrameStart(bnd[1]),
    .serialMsgStart(bnd[2]), .diagPwm(diagV[0]), .diagSent(diagV[1]), .diagSerial(diagV[2]),
    .diagAnalog(diagAnalog), .portForce(portForce), .errCond(errCond), .lbistStart(lbistStart),
    .lbistDone(lbistDone), .lbistPass(lbistPass), .lbistSig(lbistSig), .tempVal(tempVal),
    .angleVal(angleVal), .chanA(chanA), .chanB(chanB), .chanAPre(chanAPre), .chanBPre(chanBPre),
    .radiusSq(radiusSq), .shadowImage(shadowImage));
  smd_nvm_model i_nvm (.ref_clk(ref_clk), .nrst(nrst), .nvmReq(nvmReq), .nvmWe(nvmWe), .nvmAddr(nvmAddr),
    .nvmWdata(nvmWdata), .nvmMargin(nvmMargin), .slow(slow), .nvmAck(nvmAck), .nvmRdata(nvmRdata),
    .nvmMarginFail(nvmMarginFail));

  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk) begin
    if (lbistStart === 1'b1) lbSeen <= 1'b1;
  end

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic give_verdict();
    if (error_cnt == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : give_verdict

  task automatic stall(input string nm);
    check(nm, 32'h0, 32'h1);
    give_verdict();
  endtask : stall

  // request held until taken at a ready edge
  task automatic cmd(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    cmdValid <= 1'b1;
    cmdWrite <= w;
    cmdAddr <= a;
    cmdWdata <= d;
    do begin
      @(posedge ref_clk);
      n++;
    end while (cmdReady !== 1'b1 && n < 400);
    cmdValid <= 1'b0;
    if (n >= 400) stall("command taken");
  endtask : cmd

  task automatic rd(input logic [7:0] a);
    got = 1'b0;
    cmd(1'b0, a, 32'h0);
    for (int n = 0; n < 16 && !got; n++) begin
      @(posedge ref_clk);
      if (rspValid === 1'b1) begin
        got = 1'b1;
        rdat = rspData;
      end
    end
  endtask : rd

  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic rep);
    rd(a);
    check("reply present", {31'h0, got}, {31'h0, rep});
    if (rep && got) check("reply data", rdat, e);
  endtask : rdc

  task automatic waitRdy();
    int n;
    for (n = 0; n < 600 && cmdReady !== 1'b1; n++) @(posedge ref_clk);
    if (n >= 600) stall("ready");
  endtask : waitRdy

  task automatic mpoll();
    int n;
    n = 0;
    do begin
      rd(8'h83);
      n++;
    end while (rdat[0] !== 1'b0 && n < 400);
    if (n >= 400) stall("margin end");
  endtask : mpoll

  task automatic pulse(input int k);
    @(posedge ref_clk);
    bnd[k] <= 1'b1;
    @(posedge ref_clk);
    bnd[k] <= 1'b0;
    repeat (2) @(posedge ref_clk);
  endtask : pulse

  initial begin
    repeat (2) @(posedge ref_clk);
    nrst <= 1'b1;
    waitRdy();
    check("load", {6'h0, shadowImage[5]}, {6'h0, i_nvm.mem[5][25:0]});
    rdc(8'h86, 32'h0, 1'b1);
    rdc(8'h45, 32'h0, 1'b0);
    rdc(8'h3c, {6'h0, i_nvm.mem[60][25:0]}, 1'b1);
    @(posedge ref_clk);
    customerUnlock <= 1'b1;
    @(posedge ref_clk);
    customerUnlock <= 1'b0;
    rdc(8'h45, {6'h0, i_nvm.mem[5][25:0]}, 1'b1);
    rdc(8'h05, {6'h0, i_nvm.mem[5][25:0]}, 1'b1);
    cmd(1'b1, 8'h46, 32'hffff_ffff);
    rdc(8'h46, 32'h03ff_ffff, 1'b1);
    cmd(1'b1, 8'h07, 32'hfedc_ba98);
    repeat (2) @(posedge ref_clk);
    waitRdy();
    check("array write", {6'h0, shadowImage[7]}, 32'h02dc_ba98);
    rdc(8'h07, 32'h02dc_ba98, 1'b1);
    rdc(8'ha2, 32'h0, 1'b0);
    rdc(8'hff, 32'h0, 1'b0);
    rdc(8'ha7, {tempVal, angleVal}, 1'b1);
    rdc(8'ha8, {chanB, chanA}, 1'b1);
    rdc(8'ha9, {chanBPre, chanAPre}, 1'b1);
    rdc(8'haa, {15'h0, radiusSq}, 1'b1);
    rdc(8'ha1, lbistSig, 1'b1);
    rdc(8'h85, 32'h0000_0030, 1'b1);
    cmd(1'b1, 8'h60, 32'h0000_0010);
    errCond <= 13'h0011;
    repeat (3) @(posedge ref_clk);
    check("analog diag", {19'h0, diagAnalog}, 32'h1);
    rdc(8'ha3, 32'h1, 1'b1);
    errCond <= 13'h0;
    for (int k = 0; k < 3; k++) begin
      pulse(k);
      pulse(k);
      errCond <= 13'h0002;
      @(posedge ref_clk);
      errCond <= 13'h0;
      repeat (3) @(posedge ref_clk);
      check("diag early", {19'h0, diagV[k]}, 32'h0);
      pulse(k);
      check("diag shown", {19'h0, diagV[k]}, 32'h2);
      pulse(k);
      check("diag cleared", {19'h0, diagV[k]}, 32'h0);
    end
    cmd(1'b1, 8'ha0, 32'h0000_0080);
    @(posedge ref_clk);
    check("force on", {31'h0, portForce}, 32'h1);
    rdc(8'ha0, 32'h0000_0080, 1'b1);
    cmd(1'b1, 8'ha0, 32'h0000_0001);
    repeat (3) @(posedge ref_clk);
    check("force off", {31'h0, portForce}, 32'h0);
    check("selftest start", {31'h0, lbSeen}, 32'h1);
    cmd(1'b1, 8'h83, 32'h0000_0001);
    mpoll();
    check("margin fail", rdat, 32'h0000_04b0);
    slow <= 1'b1;
    cmd(1'b1, 8'h83, 32'h0000_0541);
    mpoll();
    check("margin custom", rdat & 32'h0000_0059, 32'h0000_0048);
    cmd(1'b1, 8'h83, 32'h0000_21c1);
    repeat (40) @(posedge ref_clk);
    check("repeat word", {26'h0, nvmAddr}, 32'h3);
    rd(8'h83);
    check("running", rdat & 32'h0000_0019, 32'h0000_0019);
    cmd(1'b1, 8'h83, 32'h0000_21c0);
    repeat (10) @(posedge ref_clk);
    rd(8'h83);
    check("aborted", rdat & 32'h0000_0019, 32'h0);
    cmd(1'b1, 8'h83, 32'h0000_0003);
    mpoll();
    check("margin lower only", rdat & 32'h0000_001f, 32'h0000_000a);
    outMode <= 2'h0;
    rdc(8'ha3, 32'h0, 1'b0);
    @(posedge ref_clk);
    accessCodeOk <= 1'b1;
    @(posedge ref_clk);
    accessCodeOk <= 1'b0;
    rdc(8'h86, 32'h0000_0002, 1'b1);
    outMode <= 2'h1;
    cmd(1'b1, 8'ha2, 32'h0000_0001);
    repeat (2) @(posedge ref_clk);
    waitRdy();
    check("reload", {6'h0, shadowImage[6]}, {6'h0, i_nvm.mem[6][25:0]});
    rdc(8'h45, 32'h0, 1'b0);
    give_verdict();
  end
endmodule : tb_top
